// ==== rtl/pbs_consts.svh ====
// Purpose: Named offsets, field positions and codes for the burst SRAM port
// Assumes: Included by bare name from the package and the modules
// Notes:   Definitions only
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH

// Register bus
`define PBS_AXI_AW        4
`define PBS_OFS_STATUS    4'h0
`define PBS_OFS_COUNT     4'h4
`define PBS_RESP_OKAY     2'h0
`define PBS_RESP_SLVERR   2'h2
`define PBS_ZERO_WORD     32'h0000_0000
`define PBS_COUNT_ONE     32'h0000_0001

// Status register fields
`define PBS_ST_ACTIVE     0
`define PBS_ST_WRITE      1
`define PBS_ST_POS_LO     2
`define PBS_ST_POS_HI     3
`define PBS_ST_INTERLEAVE 4
`define PBS_ST_DRIVE      5

// Data lanes and burst
`define PBS_LANE_W        8
`define PBS_BURST_W       2
`define PBS_BURST_ZERO    2'h0
`define PBS_BURST_STEP    2'h1

`endif

// ==== rtl/pbs_pkg.sv ====
// Purpose: Shared types for the burst SRAM port
// Assumes: Constants come from pbs_consts.svh
// Notes:   Types only
`include "pbs_consts.svh"

package pbs_pkg;

   typedef struct packed {
      logic valid;
      logic write;
   } pbs_ctl_t;

   typedef struct packed {
      logic                    drive;
      logic                    interleave;
      logic [`PBS_BURST_W-1:0] pos;
      logic                    write;
      logic                    active;
   } pbs_status_t;

   typedef enum logic {
      WR_IDLE,
      WR_RESP
   } pbs_wr_state_t;

endpackage

// ==== rtl/pbs_burst_ctr.sv ====
// Purpose: Two-bit burst position counter, linear or interleaved
// Assumes: load and step are already qualified by the clock qualifier
// Notes:   Position wraps inside the group of four
`timescale 1ns/100ps
`include "pbs_consts.svh"

module pbs_burst_ctr
   import pbs_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic                    load,
   input  wire logic                    step,
   input  wire logic [`PBS_BURST_W-1:0] start_low,
   input  wire logic                    interleave,
   output logic      [`PBS_BURST_W-1:0] pos_low
);

   logic [`PBS_BURST_W-1:0] start_reg;
   logic [`PBS_BURST_W-1:0] count_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         start_reg <= `PBS_BURST_ZERO;
         count_reg <= `PBS_BURST_ZERO;
      end else if (load) begin
         start_reg <= start_low;
         count_reg <= `PBS_BURST_ZERO;
      end else if (step) begin
         count_reg <= count_reg + `PBS_BURST_STEP;
      end
   end

   assign pos_low = interleave ? (start_reg ^ count_reg) : (start_reg + count_reg);

endmodule

// ==== rtl/pbs_mem_array.sv ====
// Purpose: Storage core with per-lane data and parity write
// Assumes: One write and one combinational read per clock
// Notes:   No reset; contents undefined until written
`timescale 1ns/100ps
`include "pbs_consts.svh"

module pbs_mem_array
   import pbs_pkg::*;
#(
   parameter int ADDR_W = 18,
   parameter int LANES  = 4
)(
   input  wire logic                          clock,
   input  wire logic                          wr_en,
   input  wire logic [ADDR_W-1:0]             wr_addr,
   input  wire logic [LANES-1:0]              wr_lane_n,
   input  wire logic [LANES*`PBS_LANE_W-1:0]  wr_data,
   input  wire logic [LANES-1:0]              wr_par,
   input  wire logic [ADDR_W-1:0]             rd_addr,
   output logic      [LANES*`PBS_LANE_W-1:0]  rd_data,
   output logic      [LANES-1:0]              rd_par
);

   localparam int SLOT_W = `PBS_LANE_W + 1;

   if (LANES < 1 || ADDR_W < `PBS_BURST_W) begin : g_bad_size
      $error("pbs_mem_array: unsupported lane count or address width");
   end

   logic [LANES*SLOT_W-1:0] store [2**ADDR_W];

   // Unselected lanes keep their old contents
   always_ff @(posedge clock) begin
      if (wr_en) begin
         for (int i = 0; i < LANES; i++) begin
            if (!wr_lane_n[i]) begin
               store[wr_addr][i*SLOT_W +: SLOT_W] <=
                  {wr_par[i], wr_data[i*`PBS_LANE_W +: `PBS_LANE_W]};
            end
         end
      end
   end

   always_comb begin
      rd_data = '0;
      rd_par  = '0;
      for (int i = 0; i < LANES; i++) begin
         rd_data[i*`PBS_LANE_W +: `PBS_LANE_W] =
            store[rd_addr][i*SLOT_W +: `PBS_LANE_W];
         rd_par[i] = store[rd_addr][i*SLOT_W + `PBS_LANE_W];
      end
   end

endmodule

// ==== rtl/pbs_port.sv ====
// Purpose: Pipelined burst SRAM pin logic with a small AXI4-Lite status port
// Assumes: Single rising-edge clock; pins synchronous to it
// Notes:   Data and parity pins split into in, out and enable
// Behaviour
// - Advance high on qualified edge steps burst
// - Load low takes a fresh start address
// - Inputs sampled only on qualified rising edges
// - Clock qualifier high freezes pin-side state; AXI side and count clear still run
// - Address, controls, selects, data captured in registers
// - Select needs all three chip selects active
// - Output drive pin gates data pins asynchronously
// - Pins released in write, reentry, deselect
// - Input data captured on rising edge
// - Read data one cycle after address
// - Parity lanes follow data lanes and selects
// - Strap high interleaved, low linear order
// - Unconnected strap reads as interleaved
// - Byte selects with strobe write own lanes
// - Burst uses two low bits, wraps at four
// - Direction latched at burst start
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "pbs_consts.svh"

module pbs_port
   import pbs_pkg::*;
#(
   parameter int ADDR_W = 18,
   parameter int LANES  = 4
)(
   input  wire logic                          clock,
   input  wire logic                          rst,
   input  wire logic                          clock_qualify_n,
   input  wire logic                          advance_or_load,
   input  wire logic                          write_strobe_n,
   input  wire logic                          chip_select_a_n,
   input  wire logic                          chip_select_b,
   input  wire logic                          chip_select_c_n,
   input  wire logic [LANES-1:0]              byte_write_sel_n,
   input  wire logic [ADDR_W-1:0]             address,
   input  wire logic                          output_drive_n,
   input  wire logic                          burst_order_strap = 1'b1,
   input  wire logic [LANES*`PBS_LANE_W-1:0]  data_in,
   output logic      [LANES*`PBS_LANE_W-1:0]  data_out,
   output logic                               data_oe,
   input  wire logic [LANES-1:0]              parity_in,
   output logic      [LANES-1:0]              parity_out,
   output logic                               parity_oe,
   input  wire logic [`PBS_AXI_AW-1:0]        s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic      [1:0]                    s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [`PBS_AXI_AW-1:0]        s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic      [31:0]                   s_axi_rdata,
   output logic      [1:0]                    s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready
);

   localparam int DATA_W = LANES * `PBS_LANE_W;
   localparam int HI_W   = ADDR_W - `PBS_BURST_W;

   if (LANES < 1 || LANES > 4 || ADDR_W <= `PBS_BURST_W) begin : g_bad_size
      $error("pbs_port: unsupported lane count or address width");
   end

   function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] sel_n);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         m[i*`PBS_LANE_W +: `PBS_LANE_W] = {`PBS_LANE_W{~sel_n[i]}};
      end
      return m;
   endfunction

   // Pin decode
   logic qual;
   logic selected;
   logic load;
   logic adv;

   assign qual     = ~clock_qualify_n;
   assign selected = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;
   assign load     = qual & ~advance_or_load;
   assign adv      = qual & advance_or_load;

   // Burst order strap, caught while reset is held
   logic mode_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         mode_reg <= burst_order_strap;
      end
   end

   // Address stage
   pbs_ctl_t         s1_ctl_reg;
   logic [HI_W-1:0]  s1_hi_reg;
   logic [LANES-1:0] s1_bw_reg;
   logic             burst_active_reg;
   logic             burst_write_reg;
   logic [`PBS_BURST_W-1:0] pos_low;
   logic [ADDR_W-1:0] s1_addr;

   pbs_burst_ctr u_ctr (
      .clock      (clock),
      .rst        (rst),
      .load       (load),
      .step       (adv),
      .start_low  (address[`PBS_BURST_W-1:0]),
      .interleave (mode_reg),
      .pos_low    (pos_low)
   );

   assign s1_addr = {s1_hi_reg, pos_low};

   always_ff @(posedge clock) begin
      if (rst) begin
         s1_ctl_reg       <= '0;
         s1_hi_reg        <= '0;
         s1_bw_reg        <= '1;
         burst_active_reg <= 1'b0;
         burst_write_reg  <= 1'b0;
      end else if (load) begin
         s1_ctl_reg.valid <= selected;
         s1_ctl_reg.write <= ~write_strobe_n;
         s1_hi_reg        <= address[ADDR_W-1:`PBS_BURST_W];
         s1_bw_reg        <= byte_write_sel_n;
         burst_active_reg <= selected;
         burst_write_reg  <= ~write_strobe_n;
      end else if (adv) begin
         s1_ctl_reg.valid <= burst_active_reg;
         s1_ctl_reg.write <= burst_write_reg;
         s1_bw_reg        <= byte_write_sel_n;
      end
   end

   // Data stage
   logic              rd_phase_reg;
   logic              wr_phase_reg;
   logic [ADDR_W-1:0] s2_addr_reg;
   logic [LANES-1:0]  s2_bw_reg;
   logic [DATA_W-1:0] core_data;
   logic [LANES-1:0]  core_par;
   logic [DATA_W-1:0] fwd_data;
   logic [LANES-1:0]  fwd_par;
   logic              fwd_hit;
   logic              mem_wr;

   assign mem_wr = qual & wr_phase_reg;

   pbs_mem_array #(
      .ADDR_W (ADDR_W),
      .LANES  (LANES)
   ) u_mem (
      .clock     (clock),
      .wr_en     (mem_wr),
      .wr_addr   (s2_addr_reg),
      .wr_lane_n (s2_bw_reg),
      .wr_data   (data_in),
      .wr_par    (parity_in),
      .rd_addr   (s1_addr),
      .rd_data   (core_data),
      .rd_par    (core_par)
   );

   // Write landing on the same edge as a read of that word
   assign fwd_hit  = mem_wr & (s2_addr_reg == s1_addr);
   assign fwd_data = fwd_hit ? ((core_data & ~lane_mask(s2_bw_reg)) |
                                (data_in & lane_mask(s2_bw_reg))) : core_data;
   assign fwd_par  = fwd_hit ? ((core_par & s2_bw_reg) | (parity_in & ~s2_bw_reg))
                             : core_par;

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_phase_reg <= 1'b0;
         wr_phase_reg <= 1'b0;
         s2_addr_reg  <= '0;
         s2_bw_reg    <= '1;
      end else if (qual) begin
         rd_phase_reg <= s1_ctl_reg.valid & ~s1_ctl_reg.write;
         wr_phase_reg <= s1_ctl_reg.valid & s1_ctl_reg.write;
         s2_addr_reg  <= s1_addr;
         s2_bw_reg    <= s1_bw_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         data_out   <= '0;
         parity_out <= '0;
      end else if (qual && s1_ctl_reg.valid && !s1_ctl_reg.write) begin
         data_out   <= fwd_data;
         parity_out <= fwd_par;
      end
   end

   // Pins drive only in a read data phase and while output drive is low
   assign data_oe   = rd_phase_reg & ~output_drive_n;
   assign parity_oe = data_oe;

   // Access counter and status
   logic [31:0] count_reg;
   logic        count_clr;
   pbs_status_t status;

   assign status.drive      = rd_phase_reg;
   assign status.interleave = mode_reg;
   assign status.pos        = pos_low;
   assign status.write      = burst_write_reg;
   assign status.active     = burst_active_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         count_reg <= `PBS_ZERO_WORD;
      end else if (mem_wr || (qual && rd_phase_reg)) begin
         count_reg <= count_clr ? `PBS_COUNT_ONE : count_reg + `PBS_COUNT_ONE;
      end else if (count_clr) begin
         count_reg <= `PBS_ZERO_WORD;
      end
   end

   // AXI4-Lite write side
   pbs_wr_state_t           wr_state_reg;
   logic                    aw_full_reg;
   logic                    w_full_reg;
   logic [`PBS_AXI_AW-1:0]  aw_addr_reg;
   logic [1:0]              bresp_reg;

   assign s_axi_awready = ~aw_full_reg & (wr_state_reg == WR_IDLE);
   assign s_axi_wready  = ~w_full_reg & (wr_state_reg == WR_IDLE);
   assign s_axi_bvalid  = (wr_state_reg == WR_RESP);
   assign s_axi_bresp   = bresp_reg;
   assign count_clr     = aw_full_reg & w_full_reg & (aw_addr_reg == `PBS_OFS_COUNT);

   always_ff @(posedge clock) begin
      if (rst) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (aw_full_reg && w_full_reg) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         w_full_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_reg <= 1'b1;
      end else if (aw_full_reg && w_full_reg) begin
         w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_state_reg <= WR_IDLE;
         bresp_reg    <= `PBS_RESP_OKAY;
      end else begin
         case (wr_state_reg)
            WR_IDLE: begin
               if (aw_full_reg && w_full_reg) begin
                  wr_state_reg <= WR_RESP;
                  bresp_reg    <= (aw_addr_reg == `PBS_OFS_COUNT ||
                                   aw_addr_reg == `PBS_OFS_STATUS) ?
                                  `PBS_RESP_OKAY : `PBS_RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_reg <= WR_IDLE;
               end
            end
            default: begin
               wr_state_reg <= WR_IDLE;
            end
         endcase
      end
   end

   // AXI4-Lite read side
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= `PBS_ZERO_WORD;
         rresp_reg  <= `PBS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         case (s_axi_araddr)
            `PBS_OFS_STATUS: begin
               rdata_reg <= {26'h000_0000, status};
               rresp_reg <= `PBS_RESP_OKAY;
            end
            `PBS_OFS_COUNT: begin
               rdata_reg <= count_reg;
               rresp_reg <= `PBS_RESP_OKAY;
            end
            default: begin
               rdata_reg <= `PBS_ZERO_WORD;
               rresp_reg <= `PBS_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_LOAD_ADDR: assert property (load && selected |=>
      s1_addr == $past(address) && s1_ctl_reg.valid)
      else $error("load did not capture the address");
   AST_FREEZE: assert property (clock_qualify_n |=>
      $stable(s1_ctl_reg) && $stable(rd_phase_reg) && $stable(data_out) && $stable(pos_low))
      else $error("state moved while clock qualifier high");
   AST_DESELECT: assert property (load && !selected |=> !s1_ctl_reg.valid)
      else $error("unselected load started an access");
   AST_OE_ASYNC: assert property (output_drive_n |-> !data_oe && !parity_oe)
      else $error("pins driven with output drive high");
   AST_WRITE_MASK: assert property ((load && !(selected && write_strobe_n)) ##1 qual |=>
      !data_oe)
      else $error("pins driven in write or deselected phase");
   AST_READ_LAT: assert property ((load && selected && write_strobe_n) ##1 qual |=>
      rd_phase_reg)
      else $error("read data phase missing one cycle later");
   AST_LINEAR_STEP: assert property (adv && !mode_reg |=>
      pos_low == $past(pos_low) + `PBS_BURST_STEP)
      else $error("linear burst did not step by one");
   AST_INTERLEAVE_STEP: assert property (load ##1 adv && mode_reg |=>
      pos_low == ($past(address[1:0], 2) ^ `PBS_BURST_STEP))
      else $error("interleaved burst second position wrong");
   AST_DIR_HOLD: assert property (adv |=>
      s1_ctl_reg.write == $past(burst_write_reg) && s1_ctl_reg.valid == $past(burst_active_reg))
      else $error("advance changed direction or ignored active burst");
   AST_PARITY_FOLLOW: assert property (parity_oe == data_oe)
      else $error("parity enable differs from data enable");
   AST_MODE_HOLD: assert property (##1 $stable(mode_reg))
      else $error("burst order changed after reset");

   COV_READ_BURST: cover property (load && selected && write_strobe_n ##1 adv [*3]);
   COV_WRITE_BURST: cover property (load && selected && !write_strobe_n ##1 adv ##1 mem_wr);
   COV_FREEZE_READ: cover property (rd_phase_reg && clock_qualify_n [*2]);
   COV_FORWARD: cover property (fwd_hit && qual && s1_ctl_reg.valid);

endmodule

// ==== bench/pbs_bus_model.sv ====
// Purpose: Far-side data and parity wire for the burst SRAM port
// Assumes: Controller drives write data only in write data phases
// Notes:   Released wire shows the inverse of its last level
`timescale 1ns/100ps

module pbs_bus_model (
   input  wire logic        clock,
   input  wire logic        dev_oe,
   input  wire logic [35:0] dev_val,
   input  wire logic        ctl_drv,
   input  wire logic [35:0] ctl_val,
   output logic      [35:0] bus_val
);
   logic [35:0] last_val = 36'h0;

   always_comb begin
      if (dev_oe)
         bus_val = dev_val;
      else if (ctl_drv)
         bus_val = ctl_val;
      else
         bus_val = ~last_val;
   end

   always @(posedge clock) begin
      last_val <= bus_val;
   end
endmodule

// ==== bench/pipelined_burst_sram_port_tb_top.sv ====
// Purpose: Self-checking bench for the burst SRAM port
// Assumes: Default widths; pins change just after rising edges
// Notes:   Strap sampled only in reset, so order is switched by reset
`timescale 1ns/100ps
`include "pbs_consts.svh"

module pipelined_burst_sram_port_tb_top
   import pbs_pkg::*;
;
   localparam logic [8:0]  LD_RD  = 9'h0AF;
   localparam logic [8:0]  LD_WR  = 9'h020;
   localparam logic [8:0]  LD_LN  = 9'h02A;
   localparam logic [8:0]  IDLE   = 9'h08F;
   localparam logic [8:0]  ADV_X  = 9'h100;
   localparam logic [8:0]  ADV_S  = 9'h1AF;
   localparam logic [35:0] LANE_M = 36'h5_00FF_00FF;
   localparam logic [2:0]  BAD [3] = '{3'h6, 3'h0, 3'h3};
   logic        clock, rst, cqn, od_n, strap, drv, oe, p_oe;
   logic [26:0] pins;
   logic [35:0] dq, bus, mem_exp [8];
   logic [31:0] d_out, wdata, rdata, rd_w;
   logic [3:0]  p_out, awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, resp;
   int          miscompares, num_checks;

   pbs_bus_model bm (.clock(clock), .dev_oe(oe), .dev_val({p_out, d_out}),
      .ctl_drv(drv), .ctl_val(dq), .bus_val(bus));

   pbs_port dut (
      .clock(clock), .rst(rst), .clock_qualify_n(cqn), .advance_or_load(pins[26]),
      .write_strobe_n(pins[25]), .chip_select_a_n(pins[24]), .chip_select_b(pins[23]),
      .chip_select_c_n(pins[22]), .byte_write_sel_n(pins[21:18]), .address(pins[17:0]),
      .output_drive_n(od_n), .burst_order_strap(strap), .data_in(bus[31:0]),
      .data_out(d_out), .data_oe(oe), .parity_in(bus[35:32]), .parity_out(p_out),
      .parity_oe(p_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   task automatic give_verdict;
      if (miscompares == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         miscompares++;
      end
   endtask

   // Controls: advance, strobe, three selects, lane selects
   task automatic op(input logic [8:0] ctl, input logic [17:0] a, input logic dv,
                     input logic [35:0] d);
      @(posedge clock);
      pins <= {ctl, a};
      drv <= dv;
      dq <= d;
   endtask

   task automatic idle(input logic dv, input logic [35:0] d);
      op(IDLE, 18'h0_0000, dv, d);
   endtask

   task automatic rd(input logic [17:0] a, input logic [35:0] e);
      op(LD_RD, a, 1'b0, 36'h0);
      idle(1'b0, 36'h0);
      #1 chk(36'({p_oe, oe}), 36'h0);
      idle(1'b0, 36'h0);
      #1 chk({p_out, d_out}, e);
      chk(36'({p_oe, oe}), 36'h3);
      idle(1'b0, 36'h0);
      #1 chk(36'({p_oe, oe}), 36'h0);
   endtask

   task automatic burst(input logic ilv);
      logic [1:0] n;
      op(LD_RD, 18'h0_0006, 1'b0, 36'h0);
      for (int i = 0; i < 6; i++) begin
         if (i < 4)
            op(ADV_X, 18'h0_0000, 1'b0, 36'h0);
         else
            idle(1'b0, 36'h0);
         #1;
         n = 2'(i - 1);
         if (i > 0)
            chk({p_out, d_out}, mem_exp[{1'b1, ilv ? 2'h2 ^ n : 2'h2 + n}]);
      end
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic regs(input logic ilv);
      axi_rd(`PBS_OFS_STATUS, rd_w, resp);
      chk({resp, 2'h0, rd_w}, {`PBS_RESP_OKAY, 2'h0, 32'(ilv) << `PBS_ST_INTERLEAVE});
      axi_wr(`PBS_OFS_COUNT, `PBS_ZERO_WORD, resp);
      chk(36'(resp), 36'(`PBS_RESP_OKAY));
      rd(18'h0_0005, mem_exp[5]);
      axi_rd(`PBS_OFS_COUNT, rd_w, resp);
      chk({resp, 2'h0, rd_w}, {`PBS_RESP_OKAY, 2'h0, `PBS_COUNT_ONE});
      axi_rd(4'h8, rd_w, resp);
      chk({resp, 2'h0, rd_w}, {`PBS_RESP_SLVERR, 2'h0, `PBS_ZERO_WORD});
      axi_wr(4'hC, `PBS_COUNT_ONE, resp);
      chk(36'(resp), 36'(`PBS_RESP_SLVERR));
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      repeat (3000) @(posedge clock);
      miscompares++;
      give_verdict;
   end

   initial begin
      logic [35:0] nd;
      miscompares = 0;
      num_checks = 0;
      rst = 1'b1;
      cqn = 1'b0;
      od_n = 1'b0;
      strap = 1'b1;
      pins = {IDLE, 18'h0_0000};
      drv = 1'b0;
      dq = 36'h0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      for (int i = 0; i < 8; i++)
         mem_exp[i] = {4'(i) ^ 4'h9, 32'h5A3C_0F00 ^ (32'(i) * 32'h0101_0101)};
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      // Back-to-back writes mixing loads and advances, data two edges after each address
      for (int i = 0; i < 6; i++) begin
         if (i < 4)
            op(i[0] ? ADV_X : LD_WR, 18'(4 + i), i > 1, mem_exp[2 + i]);
         else
            idle(1'b1, mem_exp[2 + i]);
         #1 if (i > 0) chk(36'({p_oe, oe}), 36'h0);
      end
      for (int i = 4; i < 8; i++)
         rd(18'(i), mem_exp[i]);
      burst(1'b1);
      // Freeze mid read with a new load pending on the pins
      op(LD_RD, 18'h0_0005, 1'b0, 36'h0);
      idle(1'b0, 36'h0);
      op(LD_RD, 18'h0_0007, 1'b0, 36'h0);
      cqn <= 1'b1;
      repeat (3) @(posedge clock);
      #1 chk({p_out, d_out}, mem_exp[5]);
      chk(36'({p_oe, oe}), 36'h3);
      @(posedge clock);
      od_n <= 1'b1;
      #1 chk(36'({p_oe, oe}), 36'h0);
      @(posedge clock);
      od_n <= 1'b0;
      cqn <= 1'b0;
      idle(1'b0, 36'h0);
      idle(1'b0, 36'h0);
      #1 chk({p_out, d_out}, mem_exp[7]);
      idle(1'b0, 36'h0);
      for (int k = 0; k < 3; k++) begin
         op({2'b01, BAD[k], 4'hf}, 18'h0_0004, 1'b0, 36'h0);
         op(ADV_S, 18'h0_0000, 1'b0, 36'h0);
         idle(1'b0, 36'h0);
         #1 chk(36'({p_oe, oe}), 36'h0);
         idle(1'b0, 36'h0);
         #1 chk(36'({p_oe, oe}), 36'h0);
      end
      // Lane write, then a read of that word served on the storing edge
      nd = ~mem_exp[4];
      mem_exp[4] = (nd & LANE_M) | (mem_exp[4] & ~LANE_M);
      op(LD_LN, 18'h0_0004, 1'b0, 36'h0);
      op(LD_RD, 18'h0_0004, 1'b0, 36'h0);
      idle(1'b1, nd);
      idle(1'b0, 36'h0);
      #1 chk({p_out, d_out}, mem_exp[4]);
      rd(18'h0_0004, mem_exp[4]);
      regs(1'b1);
      @(posedge clock);
      rst <= 1'b1;
      strap <= 1'b0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      burst(1'b0);
      regs(1'b0);
      give_verdict;
   end
endmodule
